// ---- rtl/board_watchdog_reset_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module board_watchdog_reset_timer #(
  parameter logic [31:0] TIMEOUT_CYCLES = 32'(wdt_pkg::TIMEOUT_CYC),
  parameter logic [31:0] HOLD_CYCLES    = 32'(wdt_pkg::HOLD_CYC)
) (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic watchdog_enable_strap,
  input  wire logic kick,
  input  wire logic pushbutton_reset,
  output logic      board_reset,
  output logic      watchdog_caused_reset
);
  logic                      strap;
  logic                      button;
  logic                      button_meta;
  logic                      timeout_hit;
  logic                      hold_done;
  logic [wdt_pkg::CNT_W-1:0] count;
  logic [wdt_pkg::CNT_W-1:0] high_run;
  wdt_pkg::wdt_state_t       state;

  // true on the last cycle of a span of the given length
  function automatic logic reached_end(
    input logic [wdt_pkg::CNT_W-1:0] value,
    input logic [31:0]               span
  );
    return value == span - 32'h1;
  endfunction

  strap_sync u_strap (
    .clock (clock),
    .nrst  (nrst),
    .pin   (watchdog_enable_strap),
    .level (strap)
  );

  always_ff @(posedge clock) begin
    if (!nrst) begin
      button_meta <= 1'h0;
      button      <= 1'h0;
    end else begin
      button_meta <= pushbutton_reset;
      button      <= button_meta;
    end
  end

  // starved for a full period with the strap fitted
  assign timeout_hit = state == wdt_pkg::st_count && strap && !kick
                       && reached_end(count, TIMEOUT_CYCLES);
  assign hold_done   = state == wdt_pkg::st_hold && reached_end(count, HOLD_CYCLES);

  // state sequencing
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= wdt_pkg::st_idle;
    end else begin
      case (state)
        wdt_pkg::st_idle: begin
          if (strap) state <= wdt_pkg::st_count;
        end
        wdt_pkg::st_count: begin
          if (!strap) state <= wdt_pkg::st_idle;
          else if (timeout_hit) state <= wdt_pkg::st_hold;
        end
        wdt_pkg::st_hold: begin
          if (hold_done) state <= wdt_pkg::st_idle;
        end
        default: state <= wdt_pkg::st_idle;
      endcase
    end
  end

  // shared cycle counter
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count <= '0;
    end else begin
      case (state)
        wdt_pkg::st_count: begin
          if (kick || !strap) count <= '0;
          else if (timeout_hit) count <= '0;
          else count <= count + 32'h1;
        end
        wdt_pkg::st_hold: begin
          if (hold_done) count <= '0;
          else count <= count + 32'h1;
        end
        default: count <= '0;
      endcase
    end
  end

  // board reset output
  always_ff @(posedge clock) begin
    if (!nrst) begin
      board_reset <= 1'h0;
    end else begin
      board_reset <= timeout_hit || (state == wdt_pkg::st_hold && !hold_done);
    end
  end

  // reset cause; survives the board reset it drives, cleared by power-on or button
  always_ff @(posedge clock) begin
    if (!nrst) begin
      watchdog_caused_reset <= wdt_pkg::CAUSE_RESET;
    end else if (state == wdt_pkg::st_hold) begin
      watchdog_caused_reset <= 1'h1;
    end else if (button) begin
      watchdog_caused_reset <= 1'h0;
    end
  end

  // assertion helper: length of the current reset pulse
  always_ff @(posedge clock) begin
    if (!nrst) begin
      high_run <= '0;
    end else if (board_reset) begin
      high_run <= high_run + 32'h1;
    end else begin
      high_run <= '0;
    end
  end

  sequence s_hold_entry;
    $rose(board_reset);
  endsequence

  sequence s_hold_min;
    board_reset [*8];
  endsequence

  sequence s_starved;
    timeout_hit;
  endsequence

  sequence s_released;
    $fell(board_reset) ##0 strap;
  endsequence

  // enable strap
  a_no_strap_reset: assert property (
    @(posedge clock) disable iff (!nrst)
    !$past(strap) && $past(state) != wdt_pkg::st_hold |-> !$rose(board_reset)
  ) else $error("reset without strap");

  a_strap_stops: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_count && !strap |=> state == wdt_pkg::st_idle && !board_reset
  ) else $error("counting without strap");

  a_idle_quiet: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_idle |-> count == '0 && !board_reset
  ) else $error("idle not quiet");

  // timeout
  a_timeout_fires: assert property (
    @(posedge clock) disable iff (!nrst)
    s_starved |=> board_reset && state == wdt_pkg::st_hold
  ) else $error("timeout missed");

  a_count_bounded: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_count |-> count < TIMEOUT_CYCLES
  ) else $error("count past timeout");

  // reset hold
  a_hold_length: assert property (
    @(posedge clock) disable iff (!nrst)
    s_hold_entry |-> s_hold_min
  ) else $error("reset hold too short");

  a_hold_exact: assert property (
    @(posedge clock) disable iff (!nrst)
    $fell(board_reset) && $past(nrst) |-> high_run == HOLD_CYCLES
  ) else $error("reset hold length wrong");

  a_reset_is_hold: assert property (
    @(posedge clock) disable iff (!nrst)
    board_reset == (state == wdt_pkg::st_hold)
  ) else $error("reset out of hold state");

  a_hold_no_kick: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_hold && !hold_done |=> state == wdt_pkg::st_hold
  ) else $error("hold cut short");

  // restart
  a_release_fresh: assert property (
    @(posedge clock) disable iff (!nrst)
    $fell(board_reset) |-> count == '0
  ) else $error("count not fresh");

  a_restart_count: assert property (
    @(posedge clock) disable iff (!nrst)
    s_released |=> state == wdt_pkg::st_count && count == '0
  ) else $error("no fresh period");

  // kicks
  a_kick_clears: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_count && kick |=> count == '0
  ) else $error("kick did not clear");

  a_kick_defers: assert property (
    @(posedge clock) disable iff (!nrst)
    state == wdt_pkg::st_count && kick |=> !board_reset
  ) else $error("reset despite kick");

  // reset cause
  a_cause_set: assert property (
    @(posedge clock) disable iff (!nrst)
    s_hold_entry |-> ##1 watchdog_caused_reset
  ) else $error("cause flag not set");

  a_cause_clear: assert property (
    @(posedge clock) disable iff (!nrst)
    button && state != wdt_pkg::st_hold |=> !watchdog_caused_reset
  ) else $error("cause flag not cleared");

  a_cause_holds: assert property (
    @(posedge clock) disable iff (!nrst)
    !button && state != wdt_pkg::st_hold |=> $stable(watchdog_caused_reset)
  ) else $error("cause flag changed");

endmodule // board_watchdog_reset_timer
`default_nettype wire

// ---- rtl/wdt_pkg.sv ----
// Functional notes
// - count only while enable strap fitted
// - timeout after 1.6 s without kick
// - hold board reset 50 ms on timeout
// - after release, fresh period like power-up
// - each kick clears the counter; the code clears it only in st_count, a kick during st_hold is ignored
// - readable flag: last reset was watchdog
`default_nettype none
package wdt_pkg;
  localparam int unsigned CLOCK_HZ      = 250_000_000;
  localparam int unsigned TIMEOUT_MS    = 1600;
  localparam int unsigned HOLD_MS       = 50;
  localparam int unsigned TIMEOUT_CYC   = CLOCK_HZ / 1000 * TIMEOUT_MS;
  localparam int unsigned HOLD_CYC      = CLOCK_HZ / 1000 * HOLD_MS;
  localparam int unsigned CNT_W         = 32;
  localparam logic        CAUSE_RESET   = 1'h0;

  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_count = 2'h1,
    st_hold  = 2'h3
  } wdt_state_t;
endpackage
`default_nettype wire

// ---- rtl/strap_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module strap_sync (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin,
  output logic      level
);
  logic meta;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      meta  <= 1'h0;
      level <= 1'h0;
    end else begin
      meta  <= pin;
      level <= meta;
    end
  end
endmodule // strap_sync
`default_nettype wire

// ---- testbench/host_kicker.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_kicker (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [7:0] gap,
  output logic            kick
);
  logic [7:0] cnt = 8'h0;
  initial kick = 1'h0;
  always @(negedge clock) begin
    cnt = (run && cnt < gap) ? cnt + 8'h1 : 8'h0;
    kick = run && cnt == gap;
  end
endmodule // host_kicker
`default_nettype wire

// ---- testbench/tb_board_watchdog_reset_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
  $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_board_watchdog_reset_timer;
  logic clock = 1'h0, nrst = 1'h0, strap = 1'h0, run = 1'h0, push = 1'h0;
  logic kick, board_reset, cause;
  int   num_errors = 0, samples_checked = 0, n;
  initial forever #2 clock = ~clock;
  host_kicker host_u (.clock(clock), .run(run), .gap(8'h9), .kick(kick));
  board_watchdog_reset_timer #(.TIMEOUT_CYCLES(32'h14), .HOLD_CYCLES(32'ha)) dut_u (
    .clock(clock), .nrst(nrst), .watchdog_enable_strap(strap), .kick(kick),
    .pushbutton_reset(push), .board_reset(board_reset), .watchdog_caused_reset(cause));
  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // cycles until board_reset goes high, bounded
  task automatic wait_hi(int lim, bit must);
    n = 0;
    while (board_reset !== 1'h1 && n < lim) begin @(negedge clock); n++; end
    if (must && n >= lim) begin num_errors++; end_sim(); end
  endtask
  task automatic t_strap_off();
    wait_hi(100, 0);
    `CHK("reset", 1'h0, board_reset)
    $display("t_strap_off done");
  endtask
  task automatic t_timeout();
    strap = 1'h1;
    wait_hi(40, 1);
    `CHK("first", 23, n)
    n = 0;
    while (board_reset === 1'h1 && n < 50) begin @(negedge clock); n++; end
    `CHK("hold", 10, n)
    `CHK("cause", 1'h1, cause)
    wait_hi(40, 1);
    `CHK("fresh", 21, n)
    n = 0;
    while (board_reset === 1'h1 && n < 50) begin @(negedge clock); n++; end
    `CHK("hold again", 10, n)
    $display("t_timeout done");
  endtask
  task automatic t_kicks();
    run = 1'h1;
    wait_hi(150, 0);
    `CHK("kicked", 1'h0, board_reset)
    run = 1'h0;
    $display("t_kicks done");
  endtask
  task automatic t_strap_pull();
    strap = 1'h0;
    wait_hi(60, 0);
    `CHK("pulled", 1'h0, board_reset)
    `CHK("cause kept", 1'h1, cause)
    $display("t_strap_pull done");
  endtask
  task automatic t_push();
    push = 1'h1;
    repeat (4) @(negedge clock);
    push = 1'h0;
    repeat (4) @(negedge clock);
    `CHK("cause", 1'h0, cause)
    $display("t_push done");
  endtask
  initial begin
    repeat (2) @(negedge clock);
    nrst = 1'h1;
    `CHK("cause", 1'h0, cause)
    t_strap_off();
    t_timeout();
    t_kicks();
    t_strap_pull();
    t_push();
    end_sim();
  end
endmodule // tb_board_watchdog_reset_timer
`default_nettype wire
